// ---- src/spf_pkg.sv ----
// Package with constants, register map and carrier types of the forwarder.
//
// Functional notes
// - Low-latency default mode forwards every byte at once, both directions.
// - Message mode holds data until the gap in ms elapses, default 250.
// - Custom packet mode releases on whichever enabled condition occurs first.
// - Release once the configured byte count arrives; zero disables it.
// - Release when idle time since the last byte reaches limit; zero disables.
// - Enabled first release byte marks packet ready; forwarding option applies.
// - Second release byte counts only directly after the first one.
// - Frame mode buffers up to 1024 bytes and detects a full buffer.
// - Start delimiter begins a frame; earlier bytes are discarded.
// - Enabled second start delimiter must directly follow the first.
// - Start delimiters are forwarded only with include-start set, default off.
// - End delimiter marks frame ready; forwarding option applies.
// - Enabled second end delimiter must directly follow the first.
// - Custom mode, off by default, selects packet or frame definition.
// - Four forwarding options: strip, include (default), plus one, plus two.
`default_nettype none
package spf_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int BUF_DEPTH = 1024;
	localparam int CNT_W     = 11;
	localparam int IDX_W     = 10;
	localparam int ADDR_W    = 8;

	localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_GAP   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SIZE  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IDLE  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_TRIG  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_DELIM = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h18;

	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_FRAME     = 2;
	localparam int CTRL_INCL_SOF  = 3;
	localparam int CTRL_FWD_LSB   = 4;
	localparam int CTRL_TRIG1_EN  = 8;
	localparam int CTRL_TRIG2_EN  = 9;
	localparam int CTRL_START_DELIM_SECOND_EN   = 10;
	localparam int CTRL_END_DELIM_SECOND_EN   = 11;
	localparam int STAT_STATE_LSB = 16;
	localparam int STAT_ARMED     = 18;

	localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
	localparam logic [15:0] GAP_RST   = 16'h00FA;
	localparam logic [15:0] THRU_IDLE = 16'h0001;

	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		MODE_LOWLAT = 2'b00,
		MODE_THRU   = 2'b01,
		MODE_MSG    = 2'b10,
		MODE_CUSTOM = 2'b11
	} spf_mode_t;

	typedef enum logic [1:0] {
		FWD_STRIP = 2'b00,
		FWD_INCL  = 2'b01,
		FWD_PLUS1 = 2'b10,
		FWD_PLUS2 = 2'b11
	} spf_fwd_t;

	typedef enum logic [1:0] {
		ST_COLLECT = 2'b00,
		ST_HUNT    = 2'b01,
		ST_START_DELIM_SECOND    = 2'b10,
		ST_DRAIN   = 2'b11
	} spf_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} spf_byte_t;

	typedef struct packed {
		spf_mode_t  mode;
		logic       frameDef;
		logic       inclStart;
		spf_fwd_t   fwd;
		logic       trig1En;
		logic       trig2En;
		logic       sof2En;
		logic       eof2En;
		logic [15:0] gapMs;
		logic [10:0] size;
		logic [15:0] idleMs;
		logic [7:0] trig1;
		logic [7:0] trig2;
		logic [7:0] start_delim_first;
		logic [7:0] start_delim_second;
		logic [7:0] end_delim_first;
		logic [7:0] end_delim_second;
	} spf_cfg_t;

endpackage
`default_nettype wire

// ---- src/spf_fifo2.sv ----
// Shift-register buffer with valid and ready on both sides.
`default_nettype none
module spf_fifo2 #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);

	////////////////////////////////////////////////////////////////////////
	// The head always sits in entry zero so the outputs come from flops.
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [DEPTH-1:0] vld_q;
	logic [DEPTH-1:0] vld_d;
	logic             push;
	logic             pop;

	assign inReady  = ~vld_q[DEPTH-1];
	assign outValid = vld_q[0];
	assign outData  = mem_q[0];
	assign push     = inValid & ~vld_q[DEPTH-1];
	assign pop      = vld_q[0] & outReady;

	always_comb begin
		mem_d = mem_q;
		vld_d = vld_q;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				mem_d[i] = mem_q[i+1];
				vld_d[i] = vld_q[i+1];
			end
			vld_d[DEPTH-1] = 1'b0;
		end
		if (push) begin
			for (int i = DEPTH - 1; i >= 0; i--) begin
				if (!vld_d[i] && (i == 0 || vld_d[i-1])) begin
					mem_d[i] = inData;
					vld_d[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			vld_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			vld_q <= vld_d;
			mem_q <= mem_d;
		end
	end

endmodule
`default_nettype wire

// ---- src/spf_tick.sv ----
// Millisecond tick generator.
`default_nettype none
module spf_tick #(
	parameter int CYCLES = 100000
) (
	input  wire logic ref_clk,
	input  wire logic rstn,
	output logic      tick
);

	////////////////////////////////////////////////////////////////////////
	localparam int W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         tick_d;

	always_comb begin
		tick_d = (cnt_q == LAST);
		cnt_d  = tick_d ? '0 : cnt_q + W'(1);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick  <= tick_d;
		end
	end

endmodule
`default_nettype wire

// ---- src/spf_forwarder.sv ----
// Serial packet forwarder top: APB registers, release logic and buffers.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
module spf_forwarder
	import spf_pkg::*;
#(
	parameter int MS_CYC = spf_pkg::MS_CYCLES
) (
	input  wire logic                      ref_clk,
	input  wire logic                      rstn,
	input  wire logic [spf_pkg::ADDR_W-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic                           pready,
	output logic      [31:0]               prdata,
	output logic                           pslverr,
	input  wire logic [7:0]                serRxData,
	input  wire logic                      serRxValid,
	output logic                           serRxReady,
	output spf_pkg::spf_byte_t             netTx,
	output logic                           netTxValid,
	input  wire logic                      netTxReady,
	input  wire logic [7:0]                netRxData,
	input  wire logic                      netRxValid,
	output logic                           netRxReady,
	output logic      [7:0]                serTxData,
	output logic                           serTxValid,
	input  wire logic                      serTxReady
);
	import spf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register file.
	spf_cfg_t    cfg_q;
	spf_cfg_t    cfg_d;
	logic        pready_d;
	logic [31:0] prdata_d;
	logic        pslverr_d;
	logic        apbAccess;

	spf_state_t       state_q;
	spf_state_t       state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             armed_q;
	logic             armed_d;

	function automatic logic [31:0] readReg(
		input logic [ADDR_W-1:0] a,
		input spf_cfg_t          c,
		input spf_state_t        s,
		input logic [CNT_W-1:0]  n,
		input logic              arm
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			OFF_CTRL: begin
				r[CTRL_MODE_LSB+:2] = c.mode;
				r[CTRL_FRAME]       = c.frameDef;
				r[CTRL_INCL_SOF]    = c.inclStart;
				r[CTRL_FWD_LSB+:2]  = c.fwd;
				r[CTRL_TRIG1_EN]    = c.trig1En;
				r[CTRL_TRIG2_EN]    = c.trig2En;
				r[CTRL_START_DELIM_SECOND_EN]     = c.sof2En;
				r[CTRL_END_DELIM_SECOND_EN]     = c.eof2En;
			end
			OFF_GAP:   r[15:0] = c.gapMs;
			OFF_SIZE:  r[10:0] = c.size;
			OFF_IDLE:  r[15:0] = c.idleMs;
			OFF_TRIG:  r[15:0] = {c.trig2, c.trig1};
			OFF_DELIM: r = {c.end_delim_second, c.end_delim_first, c.start_delim_second, c.start_delim_first};
			OFF_STAT: begin
				r[CNT_W-1:0]          = n;
				r[STAT_STATE_LSB+:2]  = s;
				r[STAT_ARMED]         = arm;
			end
			default:   r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign apbAccess = psel & penable;

	always_comb begin
		cfg_d     = cfg_q;
		pready_d  = apbAccess & ~pready;
		prdata_d  = prdata;
		pslverr_d = 1'b0;
		if (apbAccess && !pready) begin
			prdata_d  = readReg(paddr, cfg_q, state_q, cnt_q, armed_q);
			pslverr_d = (paddr > OFF_STAT) || (paddr[1:0] != 2'b00);
		end
		if (apbAccess && pready && pwrite) begin
			unique case (paddr)
				OFF_CTRL: begin
					// A two-bit code and one bit keep the choice exclusive.
					cfg_d.mode      = spf_mode_t'(pwdata[CTRL_MODE_LSB+:2]);
					cfg_d.frameDef  = pwdata[CTRL_FRAME];
					cfg_d.inclStart = pwdata[CTRL_INCL_SOF];
					cfg_d.fwd       = spf_fwd_t'(pwdata[CTRL_FWD_LSB+:2]);
					cfg_d.trig1En   = pwdata[CTRL_TRIG1_EN];
					cfg_d.trig2En   = pwdata[CTRL_TRIG2_EN];
					cfg_d.sof2En    = pwdata[CTRL_START_DELIM_SECOND_EN];
					cfg_d.eof2En    = pwdata[CTRL_END_DELIM_SECOND_EN];
				end
				OFF_GAP:   cfg_d.gapMs  = pwdata[15:0];
				OFF_SIZE:  cfg_d.size   = pwdata[10:0];
				OFF_IDLE:  cfg_d.idleMs = pwdata[15:0];
				OFF_TRIG: begin
					cfg_d.trig1 = pwdata[7:0];
					cfg_d.trig2 = pwdata[15:8];
				end
				OFF_DELIM: begin
					cfg_d.start_delim_first = pwdata[7:0];
					cfg_d.start_delim_second = pwdata[15:8];
					cfg_d.end_delim_first = pwdata[23:16];
					cfg_d.end_delim_second = pwdata[31:24];
				end
				default: cfg_d = cfg_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q.mode      <= spf_mode_t'(CTRL_RST[CTRL_MODE_LSB+:2]);
			cfg_q.frameDef  <= CTRL_RST[CTRL_FRAME];
			cfg_q.inclStart <= CTRL_RST[CTRL_INCL_SOF];
			cfg_q.fwd       <= spf_fwd_t'(CTRL_RST[CTRL_FWD_LSB+:2]);
			cfg_q.trig1En   <= CTRL_RST[CTRL_TRIG1_EN];
			cfg_q.trig2En   <= CTRL_RST[CTRL_TRIG2_EN];
			cfg_q.sof2En    <= CTRL_RST[CTRL_START_DELIM_SECOND_EN];
			cfg_q.eof2En    <= CTRL_RST[CTRL_END_DELIM_SECOND_EN];
			cfg_q.gapMs     <= GAP_RST;
			cfg_q.size      <= 11'h000;
			cfg_q.idleMs    <= 16'h0000;
			cfg_q.trig1     <= 8'h00;
			cfg_q.trig2     <= 8'h00;
			cfg_q.start_delim_first      <= 8'h00;
			cfg_q.start_delim_second      <= 8'h00;
			cfg_q.end_delim_first      <= 8'h00;
			cfg_q.end_delim_second      <= 8'h00;
			pready          <= 1'b0;
			prdata          <= 32'h0000_0000;
			pslverr         <= 1'b0;
		end else begin
			cfg_q   <= cfg_d;
			pready  <= pready_d;
			prdata  <= prdata_d;
			pslverr <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Collection buffer and release engine.
	logic [7:0]       mem_q [BUF_DEPTH];
	logic [IDX_W-1:0] rdIdx_q;
	logic [IDX_W-1:0] rdIdx_d;
	spf_state_t       post_q;
	spf_state_t       post_d;
	logic [1:0]       extra_q;
	logic [1:0]       extra_d;
	logic [15:0]      idle_q;
	logic [15:0]      idle_d;
	logic             rxRdy_d;
	logic             tick;
	logic             acc;
	logic             wrEn;
	logic [IDX_W-1:0] wrIdx;
	logic             relNow;
	spf_state_t       relPost;
	logic             pktDef;
	logic             frmDef;
	logic             firstEn;
	logic             secondEn;
	logic [7:0]       firstC;
	logic [7:0]       secondC;
	logic             endNow;
	logic             timerHit;
	spf_byte_t        txIn;
	logic             txInReady;
	logic             txInValid;
	logic             lastOut;
	logic             frmDef_q;

	spf_tick #(
		.CYCLES (MS_CYC)
	) u_tick (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.tick    (tick)
	);

	assign acc    = serRxValid & serRxReady;
	assign pktDef = (cfg_q.mode == MODE_CUSTOM) && !cfg_q.frameDef;
	assign frmDef = (cfg_q.mode == MODE_CUSTOM) && cfg_q.frameDef;

	always_comb begin
		firstEn  = pktDef ? cfg_q.trig1En : frmDef;
		secondEn = pktDef ? (cfg_q.trig1En & cfg_q.trig2En)
		                  : (frmDef & cfg_q.eof2En);
		firstC   = pktDef ? cfg_q.trig1 : cfg_q.end_delim_first;
		secondC  = pktDef ? cfg_q.trig2 : cfg_q.end_delim_second;
		// A pending second byte is honoured only right after the first.
		endNow   = (extra_q == 2'b00) &&
		           (secondEn ? (armed_q && serRxData == secondC)
		                     : (firstEn && serRxData == firstC));
		unique case (cfg_q.mode)
			MODE_CUSTOM: timerHit = pktDef && (cfg_q.idleMs != 16'h0000)
			                        && (idle_q >= cfg_q.idleMs);
			MODE_MSG:    timerHit = idle_q >= cfg_q.gapMs;
			MODE_THRU:   timerHit = idle_q >= THRU_IDLE;
			MODE_LOWLAT: timerHit = 1'b0;
		endcase
	end

	assign lastOut   = ({1'b0, rdIdx_q} == cnt_q - CNT_W'(1));
	assign txIn.data = mem_q[rdIdx_q];
	assign txIn.last = lastOut;
	assign txInValid = (state_q == ST_DRAIN);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		rdIdx_d = rdIdx_q;
		post_d  = post_q;
		extra_d = extra_q;
		armed_d = armed_q;
		idle_d  = idle_q;
		wrEn    = 1'b0;
		wrIdx   = cnt_q[IDX_W-1:0];
		relNow  = 1'b0;
		relPost = ST_COLLECT;
		if (tick && idle_q != 16'hFFFF) begin
			idle_d = idle_q + 16'h0001;
		end
		if (acc) begin
			idle_d = 16'h0000;
		end
		unique case (state_q)
			ST_HUNT: begin
				// Bytes ahead of the start delimiter are dropped.
				if (acc && serRxData == cfg_q.start_delim_first) begin
					wrEn    = cfg_q.inclStart;
					wrIdx   = '0;
					cnt_d   = cfg_q.inclStart ? CNT_W'(1) : '0;
					state_d = cfg_q.sof2En ? ST_START_DELIM_SECOND : ST_COLLECT;
				end
			end
			ST_START_DELIM_SECOND: begin
				if (acc && serRxData == cfg_q.start_delim_second) begin
					wrEn    = cfg_q.inclStart;
					cnt_d   = cfg_q.inclStart ? cnt_q + CNT_W'(1) : cnt_q;
					state_d = ST_COLLECT;
				end else if (acc && serRxData != cfg_q.start_delim_first) begin
					cnt_d   = '0;
					state_d = ST_HUNT;
				end
			end
			ST_COLLECT: begin
				if (acc) begin
					armed_d = 1'b0;
					if (extra_q != 2'b00) begin
						// Trailing bytes after the trigger.
						wrEn    = 1'b1;
						cnt_d   = cnt_q + CNT_W'(1);
						extra_d = extra_q - 2'b01;
						relNow  = (extra_q == 2'b01);
						relPost = frmDef ? ST_HUNT : ST_COLLECT;
					end else if (endNow) begin
						relPost = frmDef ? ST_HUNT : ST_COLLECT;
						if (cfg_q.fwd == FWD_STRIP) begin
							// The stored first byte of a pair goes too.
							cnt_d  = secondEn ? cnt_q - CNT_W'(1) : cnt_q;
							relNow = 1'b1;
						end else begin
							wrEn  = 1'b1;
							cnt_d = cnt_q + CNT_W'(1);
							unique case (cfg_q.fwd)
								FWD_PLUS1: extra_d = 2'b01;
								FWD_PLUS2: extra_d = 2'b10;
								default:   relNow  = 1'b1;
							endcase
						end
					end else begin
						wrEn    = 1'b1;
						cnt_d   = cnt_q + CNT_W'(1);
						armed_d = secondEn && (serRxData == firstC);
					end
					// Whichever enabled condition comes first releases.
					if (!relNow) begin
						if (cnt_d == CNT_W'(BUF_DEPTH)) begin
							relNow = 1'b1;
							relPost = ST_COLLECT;
						end else if (pktDef && cfg_q.size != 11'h000
						             && cnt_d >= cfg_q.size) begin
							relNow = 1'b1;
						end else if (cfg_q.mode == MODE_LOWLAT) begin
							relNow = 1'b1;
						end
					end
				end else if (cnt_q != '0 && timerHit) begin
					relNow = 1'b1;
				end
			end
			ST_DRAIN: begin
				if (txInReady) begin
					rdIdx_d = rdIdx_q + IDX_W'(1);
					if (lastOut) begin
						state_d = post_q;
						cnt_d   = '0;
						rdIdx_d = '0;
					end
				end
			end
		endcase
		if (relNow) begin
			armed_d = 1'b0;
			extra_d = 2'b00;
			rdIdx_d = '0;
			if (cnt_d == '0) begin
				state_d = relPost;
			end else begin
				state_d = ST_DRAIN;
				post_d  = relPost;
			end
		end
		// Besides an end delimiter, only the switch into frame mode starts a hunt, so a full buffer
		// keeps collecting the same frame.
		if (frmDef && !frmDef_q && state_d == ST_COLLECT) begin
			state_d = ST_HUNT;
			cnt_d   = '0;
		end
		if (!frmDef && (state_d == ST_HUNT || state_d == ST_START_DELIM_SECOND)) begin
			state_d = ST_COLLECT;
			cnt_d   = '0;
		end
		// Input stalls while a packet drains, so no byte is lost.
		rxRdy_d = (state_d != ST_DRAIN);
	end

	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem_q[wrIdx] <= serRxData;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= ST_COLLECT;
			cnt_q      <= '0;
			rdIdx_q    <= '0;
			post_q     <= ST_COLLECT;
			extra_q    <= 2'b00;
			armed_q    <= 1'b0;
			idle_q     <= 16'h0000;
			serRxReady <= 1'b0;
			frmDef_q   <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			rdIdx_q    <= rdIdx_d;
			post_q     <= post_d;
			extra_q    <= extra_d;
			armed_q    <= armed_d;
			idle_q     <= idle_d;
			serRxReady <= rxRdy_d;
			frmDef_q   <= frmDef;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output buffers toward the network and the serial device.
	spf_fifo2 #(
		.WIDTH ($bits(spf_byte_t)),
		.DEPTH (2)
	) u_net_buf (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.inData   (txIn),
		.inValid  (txInValid),
		.inReady  (txInReady),
		.outData  (netTx),
		.outValid (netTxValid),
		.outReady (netTxReady)
	);

	// Network data goes straight to the serial side in every mode.
	spf_fifo2 #(
		.WIDTH (8),
		.DEPTH (2)
	) u_ser_buf (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.inData   (netRxData),
		.inValid  (netRxValid),
		.inReady  (netRxReady),
		.outData  (serTxData),
		.outValid (serTxValid),
		.outReady (serTxReady)
	);

endmodule
`default_nettype wire

// ---- verif/spf_chk.sv ----
// Checker of the forwarder's bus and byte path ports.
`default_nettype none
module spf_chk
	import spf_pkg::*;
(
	input wire logic                       ref_clk,
	input wire logic                       rstn,
	input wire logic [spf_pkg::ADDR_W-1:0] paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [31:0]                pwdata,
	input wire logic                       pready,
	input wire logic [31:0]                prdata,
	input wire logic                       pslverr,
	input wire logic [7:0]                 serRxData,
	input wire logic                       serRxValid,
	input wire logic                       serRxReady,
	input wire spf_pkg::spf_byte_t         netTx,
	input wire logic                       netTxValid,
	input wire logic                       netTxReady,
	input wire logic                       netRxValid,
	input wire logic                       netRxReady,
	input wire logic                       serTxValid
);
	timeunit 1ns;
	timeprecision 1ps;
	spf_mode_t  mode_q, mode_d;
	logic [7:0] rxByte_q, rxByte_d;
	// The mode is shadowed from bus writes, since only the ports are seen.
	always_comb begin
		mode_d = mode_q;
		rxByte_d = rxByte_q;
		if (psel && penable && pready && pwrite && paddr == OFF_CTRL)
			mode_d = spf_mode_t'(pwdata[1:0]);
		if (serRxValid && serRxReady)
			rxByte_d = serRxData;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q <= MODE_LOWLAT;
			rxByte_q <= 8'h00;
		end else begin
			mode_q <= mode_d;
			rxByte_q <= rxByte_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	bus_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	bus_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	bus_refuse_a: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped not refused");
	refuse_data_a: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0) else $error("refused read data");
	lowlat_stall_a: assert property (mode_q == MODE_LOWLAT && serRxValid
		&& serRxReady |=> !serRxReady) else $error("no stall");
	lowlat_fwd_a: assert property (mode_q == MODE_LOWLAT && serRxValid
		&& serRxReady |-> ##[1:3] netTxValid) else $error("byte held");
	lowlat_data_a: assert property (mode_q == MODE_LOWLAT
		&& $rose(netTxValid) |-> netTx.data == rxByte_q && netTx.last)
		else $error("wrong byte out");
	net_to_ser_a: assert property (netRxValid && netRxReady
		|=> serTxValid) else $error("net byte lost");
	tx_hold_a: assert property (netTxValid && !netTxReady
		|=> netTxValid && $stable(netTx)) else $error("byte dropped");
endmodule
bind spf_forwarder spf_chk i_spf_chk (.*);
`default_nettype wire

// ---- verif/spf_ser_model.sv ----
// Behavioural serial device on the far side of the forwarder.
`default_nettype none
module spf_ser_model (
	input  wire logic       ref_clk,
	input  wire logic       slow,
	output logic [7:0]      serRxData,
	output logic            serRxValid,
	input  wire logic       serRxReady,
	input  wire logic [7:0] serTxData,
	input  wire logic       serTxValid,
	output logic            serTxReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	int         tmo = 0;
	initial begin
		serRxData = 8'h00;
		serRxValid = 1'b0;
	end
	// A slow device holds ready low, so the forwarder's buffer backs up.
	assign serTxReady = !slow;
	always @(posedge ref_clk) begin
		if (serTxValid && serTxReady)
			got.push_back(serTxData);
	end
	task automatic send(input logic [7:0] b);
		int n = 0;
		@(posedge ref_clk);
		serRxData <= b;
		serRxValid <= 1'b1;
		do @(posedge ref_clk); while (serRxReady !== 1'b1 && ++n < 2000);
		if (n >= 2000)
			tmo++;
		serRxValid <= 1'b0;
		// A released line shows the inverse, so stale data never matches.
		serRxData <= ~b;
	endtask
endmodule
`default_nettype wire

// ---- verif/spf_forwarder_tb.sv ----
// Self-checking bench of the serial packet forwarder.
`default_nettype none
module spf_forwarder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spf_pkg::*;
	localparam int MSC = 10;
	logic        ref_clk = 1'b0, rstn = 1'b0;
	logic [7:0]  paddr = 8'h00, netRxData = 8'h00;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, serRxValid, serRxReady;
	logic [7:0]  serRxData, serTxData;
	logic        serTxValid, serTxReady, netTxValid, netRxReady;
	logic        netRxValid = 1'b0, netTxReady = 1'b0, slow = 1'b0;
	spf_byte_t   netTx;
	spf_byte_t   txq[$];
	logic [7:0]  e[$];
	int          n_errors = 0, n_checks = 0;
	spf_forwarder #(.MS_CYC(MSC)) i_spf_forwarder (.*);
	spf_ser_model i_spf_ser_model (.*);
	always #5 ref_clk = ~ref_clk;
	// The network side stalls every other cycle to exercise the buffer.
	always @(posedge ref_clk) begin
		if (netTxValid && netTxReady)
			txq.push_back(netTx);
		netTxReady <= !netTxReady;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] s,
		input logic [31:0] x);
		n_checks++;
		if (s !== x) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic feed(input logic [7:0] q[$]);
		foreach (q[i])
			i_spf_ser_model.send(q[i]);
	endtask
	task automatic net_send(input logic [7:0] b);
		int n = 0;
		@(posedge ref_clk);
		netRxData <= b;
		netRxValid <= 1'b1;
		do @(posedge ref_clk); while (netRxReady !== 1'b1 && ++n < 50);
		netRxValid <= 1'b0;
		if (n >= 50) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic expect_pkt(input string nm);
		int n = 0;
		while (txq.size() < e.size() && n++ < 8000)
			@(posedge ref_clk);
		if (n >= 8000) begin
			n_errors++;
			end_of_test();
		end
		repeat (4) @(posedge ref_clk);
		foreach (e[i]) begin
			check(nm, {24'h0, txq[i].data}, {24'h0, e[i]});
			check(nm, {31'h0, txq[i].last}, 32'(i == e.size() - 1));
		end
		check(nm, 32'(txq.size()), 32'(e.size()));
		txq.delete();
		e.delete();
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(OFF_CTRL, 1'b0, 32'h0);
		check("ctrl", rd, CTRL_RST);
		apb(OFF_GAP, 1'b0, 32'h0);
		check("gap", rd, 32'h0000_00FA);
		apb(OFF_SIZE, 1'b0, 32'h0);
		check("size", rd, 32'h0);
		apb(OFF_IDLE, 1'b0, 32'h0);
		check("idle", rd, 32'h0);
		apb(8'h1C, 1'b0, 32'h0);
		check("unmapped err", {31'h0, er}, 32'h1);
		check("unmapped data", rd, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_lowlat();
		for (int k = 0; k < 3; k++) begin
			i_spf_ser_model.send(8'hA0 + 8'(k));
			e = '{8'hA0 + 8'(k)};
			expect_pkt("lowlat");
		end
		slow <= 1'b1;
		net_send(8'h5A);
		net_send(8'hA5);
		repeat (2) @(posedge ref_clk);
		check("net full", {31'h0, netRxReady}, 32'h0);
		slow <= 1'b0;
		repeat (6) @(posedge ref_clk);
		check("ser tx", {16'h0, i_spf_ser_model.got[0],
			i_spf_ser_model.got[1]}, 32'h5AA5);
		$display("t_lowlat done");
	endtask
	task automatic t_msg();
		apb(OFF_GAP, 1'b1, 32'h3);
		apb(OFF_CTRL, 1'b1, 32'h0000_0012);
		feed('{8'hB1, 8'hB2});
		repeat (10) @(posedge ref_clk);
		check("msg early", 32'(txq.size()), 32'h0);
		e = '{8'hB1, 8'hB2};
		expect_pkt("msg");
		apb(OFF_CTRL, 1'b1, 32'h0000_0011);
		feed('{8'hB3, 8'hB4});
		e = '{8'hB3, 8'hB4};
		expect_pkt("thru");
		$display("t_msg done");
	endtask
	task automatic t_pkt();
		apb(OFF_CTRL, 1'b1, 32'h0000_0013);
		apb(OFF_SIZE, 1'b1, 32'h3);
		feed('{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5});
		e = '{8'hC1, 8'hC2, 8'hC3};
		expect_pkt("size");
		apb(OFF_IDLE, 1'b1, 32'h2);
		e = '{8'hC4, 8'hC5};
		expect_pkt("idle");
		apb(OFF_IDLE, 1'b1, 32'h0);
		apb(OFF_SIZE, 1'b1, 32'h0);
		apb(OFF_TRIG, 1'b1, 32'h0000_6655);
		for (int f = 0; f < 4; f++) begin
			apb(OFF_CTRL, 1'b1, {20'h0, 4'h1, 2'b00, 2'(f), 4'h3});
			e = '{8'hD1, 8'h55, 8'hE1, 8'hE2};
			e = e[0:((f < 2) ? 1 : f)];
			feed(e);
			if (f == 0)
				e = e[0:0];
			expect_pkt("trigger");
		end
		apb(OFF_CTRL, 1'b1, 32'h0000_0313);
		e = '{8'h55, 8'hF1, 8'h55, 8'h66};
		feed(e);
		expect_pkt("trigger pair");
		$display("t_pkt done");
	endtask
	task automatic t_frame();
		apb(OFF_DELIM, 1'b1, 32'h7C7F_7D7E);
		apb(OFF_CTRL, 1'b1, 32'h0000_0017);
		feed('{8'h11, 8'h7E, 8'h22, 8'h7F});
		e = '{8'h22, 8'h7F};
		expect_pkt("frame");
		apb(OFF_STAT, 1'b0, 32'h0);
		check("stat", rd, 32'h0001_0000);
		apb(OFF_CTRL, 1'b1, 32'h0000_0C1F);
		e = '{8'h7E, 8'h33, 8'h7E, 8'h7D, 8'h44, 8'h7F, 8'h55, 8'h7F, 8'h7C};
		feed(e);
		e = e[2:$];
		expect_pkt("frame pair");
		apb(OFF_CTRL, 1'b1, 32'h0000_0017);
		i_spf_ser_model.send(8'h7E);
		for (int i = 0; i < BUF_DEPTH; i++)
			e.push_back(8'(i % 64));
		feed(e);
		expect_pkt("full");
		e = '{8'h01, 8'h7F};
		feed(e);
		expect_pkt("after full");
		$display("t_frame done");
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_lowlat();
		t_msg();
		t_pkt();
		t_frame();
		check("serial waits", 32'(i_spf_ser_model.tmo), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
